// ===== pkg/oasc_ctrl_map.vh
// Register map, field positions and constants of the oscillator and standby control
//
// Function
// RULE1: Power-mode bits seven to three read one
// RULE2: Standby flags decode normal, deep or crystal standby
// RULE3: Deep standby entry stops oscillators, clears control
// RULE4: Deep standby exit restarts main, RC; selects RC
// RULE5: Crystal standby keeps subclock, oscillator register unchanged
// RULE6: Software picks subclock or RC before crystal standby
// RULE7: Standby flags set and crystal flag cleared by software
// RULE8: Reset or release event clears deep standby flag
// RULE9: Setting deep standby flag also sets halt flag
// RULE10: Halt flag suspends core, peripherals keep running
// RULE11: Accepted interrupt or reset clears halt flag
// RULE12: Pin level bits read-only, others read/write
// RULE13: No-halving bit selects full or half clock
// RULE14: Two-bit select picks RC, main or subclock
// RULE15: Pin mode decides what pin level bits return
// RULE16: RC stop bit halts RC oscillator, cleared by hardware
// RULE17: Main stop bit halts main oscillator, cleared by hardware
// RULE18: Spare flags of pin port register do nothing
// RULE19: Pin B drives low only when enabled, value zero
// RULE20: Pin B output disabled while pin mode set
// RULE21: Reference select field maps to resonator MHz
// RULE22: PLL runs only with both stop bits zero
// RULE23: Software writes zero to PLL test, reserved bits
// RULE24: Hardware set/clear synchronous, hardware clear beats write
`ifndef OASC_CTRL_MAP_VH
`define OASC_CTRL_MAP_VH

`define OASC_ADDR_W        18
`define OASC_IDX_USB_CLOCK_DIVIDER_CTRL    16'hfe04
`define OASC_IDX_POWER     16'hfe07
`define OASC_IDX_PLL       16'hfe0d
`define OASC_IDX_OSC       16'hfe0e
`define OASC_IDX_PINPORT   16'hfe43
`define OASC_ADDR_USB_CLOCK_DIVIDER_CTRL   ({`OASC_IDX_USB_CLOCK_DIVIDER_CTRL, 2'b00})
`define OASC_ADDR_POWER    ({`OASC_IDX_POWER, 2'b00})
`define OASC_ADDR_PLL      ({`OASC_IDX_PLL, 2'b00})
`define OASC_ADDR_OSC      ({`OASC_IDX_OSC, 2'b00})
`define OASC_ADDR_PINPORT  ({`OASC_IDX_PINPORT, 2'b00})

`define OASC_RST_BYTE      8'h00
`define OASC_RST_BIT       1'b0
`define OASC_ZERO_WORD     32'h00000000
`define OASC_ZERO_PAD      24'h000000

`define OASC_PWR_HALT      0
`define OASC_PWR_DEEP      1
`define OASC_PWR_XTAL      2
`define OASC_PWR_UNUSED    5'h1f

`define OASC_OSC_MAIN_STOP 0
`define OASC_OSC_RC_STOP   1
`define OASC_OSC_SEL_LO    4
`define OASC_OSC_SEL_HI    5
`define OASC_OSC_PIN_MODE  6
`define OASC_OSC_NO_HALF   7
`define OASC_OSC_WR_MASK   8'hf3
`define OASC_OSC_DEEP_KEEP 8'hcc

`define OASC_PIN_VALUE     0
`define OASC_PIN_DRIVE     1

`define OASC_PLL_CMP_STOP  2
`define OASC_PLL_VCO_STOP  3
`define OASC_PLL_REF_LO    5
`define OASC_PLL_REF_HI    7

`define OASC_SRC_RC        2'h0
`define OASC_SRC_MAIN      2'h1
`define OASC_SRC_SUB       2'h2
`define OASC_SEL_SUB       2'h2

`define OASC_REF_SEL0      3'h0
`define OASC_REF_SEL1      3'h1
`define OASC_REF_SEL2      3'h2
`define OASC_REF_SEL3      3'h3
`define OASC_REF_SEL4      3'h4
`define OASC_REF_SEL5      3'h5
`define OASC_REF_SEL6      3'h6
`define OASC_REF_MHZ0      5'h08
`define OASC_REF_MHZ1      5'h09
`define OASC_REF_MHZ2      5'h0a
`define OASC_REF_MHZ3      5'h0b
`define OASC_REF_MHZ4      5'h0c
`define OASC_REF_MHZ5      5'h02
`define OASC_REF_MHZ6      5'h03
`define OASC_REF_MHZ7      5'h10

`define OASC_SYNC_W        10
`define OASC_SYNC_PIN_A    9
`define OASC_SYNC_PIN_B    8
`define OASC_SYNC_WAKE_HI  7

`endif

// ===== logic/oasc_ctrl.v
// Oscillator, system clock select and standby mode control with APB registers
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "oasc_ctrl_map.vh"

module oasc_ctrl (
   input  wire                     sys_clk,
   input  wire                     resetn,
   input  wire                     psel,
   input  wire                     penable,
   input  wire                     pwrite,
   input  wire [`OASC_ADDR_W-1:0]  paddr,
   input  wire [31:0]              pwdata,
   input  wire [3:0]               pstrb,
   output reg  [31:0]              prdata,
   output reg                      pready,
   output reg                      pslverr,
   input  wire [4:0]               extIntWake,
   input  wire                     port0Wake,
   input  wire                     usbActiveWake,
   input  wire                     remoteRxWake,
   input  wire                     irqAccept,
   input  wire                     pinAIn,
   input  wire                     pinBIn,
   output reg                      coreHalted,
   output reg                      deepStandby,
   output reg                      crystalStandby,
   output reg                      mainOscRun,
   output reg                      rcOscRun,
   output reg                      subOscRun,
   output reg                      pllRun,
   output reg  [1:0]               sysclkSource,
   output reg                      sysclkHalve,
   output reg                      pinBOut,
   output reg                      pinBOe,
   output reg  [4:0]               pllRefMhz,
   output reg  [7:0]               usbDivSetting
);

   // Asynchronous inputs, gathered for the synchronisers
   wire [`OASC_SYNC_W-1:0] asyncIn;
   reg  [`OASC_SYNC_W-1:0] syncStage1;
   reg  [`OASC_SYNC_W-1:0] syncStage2;

   // Stored register state
   reg                     haltFlag;
   reg                     deepFlag;
   reg                     xtalFlag;
   reg  [7:0]              oscReg;
   reg  [7:0]              pinPortReg;
   reg  [7:0]              pllReg;
   reg  [7:0]              usbDivReg;

   // Next values
   reg                     next_haltFlag;
   reg                     next_deepFlag;
   reg                     next_xtalFlag;
   reg  [7:0]              next_oscReg;
   reg  [7:0]              next_pinPortReg;
   reg  [7:0]              next_pllReg;
   reg  [7:0]              next_usbDivReg;
   reg  [1:0]              next_source;
   reg  [4:0]              next_refMhz;

   // Bus decode
   reg                     hitUsbDiv;
   reg                     hitPower;
   reg                     hitPll;
   reg                     hitOsc;
   reg                     hitPinPort;
   reg  [7:0]              readByte;
   wire                    mapped;
   wire                    setupPhase;
   wire                    accessDone;
   wire                    writeTaken;

   // Qualified events
   wire                    pinALevel;
   wire                    pinBLevel;
   wire                    wakeAny;
   wire                    powerWrite;
   wire                    enterDeep;

   assign asyncIn = {pinAIn, pinBIn, extIntWake, port0Wake,
                     usbActiveWake, remoteRxWake};

   genvar i;
   generate
      for (i = 0; i < `OASC_SYNC_W; i = i + 1) begin : gSync
         always @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               syncStage1[i] <= `OASC_RST_BIT;
               syncStage2[i] <= `OASC_RST_BIT;
            end else begin
               syncStage1[i] <= asyncIn[i];
               syncStage2[i] <= syncStage1[i];
            end
         end
      end
   endgenerate

   assign pinALevel = syncStage2[`OASC_SYNC_PIN_A];
   assign pinBLevel = syncStage2[`OASC_SYNC_PIN_B];
   // Any release source held high frees deep standby
   assign wakeAny   = |syncStage2[`OASC_SYNC_WAKE_HI:0];   // see RULE8

   // Address decode of the five byte registers, one per word
   always @* begin
      hitUsbDiv  = (paddr == `OASC_ADDR_USB_CLOCK_DIVIDER_CTRL);
      hitPower   = (paddr == `OASC_ADDR_POWER);
      hitPll     = (paddr == `OASC_ADDR_PLL);
      hitOsc     = (paddr == `OASC_ADDR_OSC);
      hitPinPort = (paddr == `OASC_ADDR_PINPORT);
   end

   assign mapped     = hitUsbDiv | hitPower | hitPll | hitOsc | hitPinPort;
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & pready;
   assign writeTaken = accessDone & pwrite & pstrb[0] & ~pslverr;
   assign powerWrite = writeTaken & hitPower;
   // Deep standby begins when software sets the flag with crystal flag low
   assign enterDeep  = powerWrite & pwdata[`OASC_PWR_DEEP]
                       & ~pwdata[`OASC_PWR_XTAL] & ~wakeAny;   // see RULE2

   // Read data mux
   always @* begin
      readByte = `OASC_RST_BYTE;
      if (hitPower) begin
         readByte = {`OASC_PWR_UNUSED, xtalFlag, deepFlag,
                     haltFlag};   // see RULE1
      end else if (hitOsc) begin
         // Pin level bits are live reads, never stored
         readByte = {oscReg[7:4], pinBLevel,
                     pinALevel & ~oscReg[`OASC_OSC_PIN_MODE],
                     oscReg[1:0]};   // see RULE12 see RULE15
      end else if (hitPinPort) begin
         readByte = pinPortReg;
      end else if (hitPll) begin
         readByte = pllReg;
      end else if (hitUsbDiv) begin
         readByte = usbDivReg;
      end
   end

   // Next state of the standby flags and control registers
   always @* begin
      next_haltFlag   = haltFlag;
      next_deepFlag   = deepFlag;
      next_xtalFlag   = xtalFlag;
      next_oscReg     = oscReg;
      next_pinPortReg = pinPortReg;
      next_pllReg     = pllReg;
      next_usbDivReg  = usbDivReg;

      if (powerWrite) begin
         // Software writes load all three flags; hardware clears follow below
         next_xtalFlag = pwdata[`OASC_PWR_XTAL];   // see RULE7
         next_deepFlag = pwdata[`OASC_PWR_DEEP];
         next_haltFlag = pwdata[`OASC_PWR_HALT]
                         | pwdata[`OASC_PWR_DEEP];   // see RULE9 see RULE10
      end
      if (writeTaken && hitOsc) begin
         next_oscReg = pwdata[7:0] & `OASC_OSC_WR_MASK;   // see RULE12
      end
      if (writeTaken && hitPinPort) begin
         // Upper bits are storage only
         next_pinPortReg = pwdata[7:0];   // see RULE18
      end
      if (writeTaken && hitPll) begin
         next_pllReg = pwdata[7:0];
      end
      if (writeTaken && hitUsbDiv) begin
         next_usbDivReg = pwdata[7:0];
      end

      // Hardware clears take priority over a write in the same cycle
      if (wakeAny) begin
         next_deepFlag = `OASC_RST_BIT;   // see RULE8 see RULE24
      end
      if (irqAccept) begin
         next_haltFlag = `OASC_RST_BIT;   // see RULE11 see RULE24
      end
      if (enterDeep) begin
         // Clears both stop bits and the clock select field
         next_oscReg = next_oscReg
                       & `OASC_OSC_DEEP_KEEP;   // see RULE3 see RULE16 see RULE17
      end
   end

   // Clock source decode; both main codes select the main clock
   always @* begin
      case ({next_oscReg[`OASC_OSC_SEL_HI], next_oscReg[`OASC_OSC_SEL_LO]})
         `OASC_SRC_RC:  next_source = `OASC_SRC_RC;    // see RULE14
         `OASC_SEL_SUB: next_source = `OASC_SRC_SUB;
         default:       next_source = `OASC_SRC_MAIN;
      endcase
   end

   // Resonator frequency in MHz from the reference select field
   always @* begin
      case (next_pllReg[`OASC_PLL_REF_HI:`OASC_PLL_REF_LO])
         `OASC_REF_SEL0: next_refMhz = `OASC_REF_MHZ0;   // see RULE21
         `OASC_REF_SEL1: next_refMhz = `OASC_REF_MHZ1;
         `OASC_REF_SEL2: next_refMhz = `OASC_REF_MHZ2;
         `OASC_REF_SEL3: next_refMhz = `OASC_REF_MHZ3;
         `OASC_REF_SEL4: next_refMhz = `OASC_REF_MHZ4;
         `OASC_REF_SEL5: next_refMhz = `OASC_REF_MHZ5;
         `OASC_REF_SEL6: next_refMhz = `OASC_REF_MHZ6;
         default:        next_refMhz = `OASC_REF_MHZ7;
      endcase
   end

   // State registers, all updates synchronous to the system clock
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         haltFlag   <= `OASC_RST_BIT;   // see RULE11
         deepFlag   <= `OASC_RST_BIT;   // see RULE8
         xtalFlag   <= `OASC_RST_BIT;
         oscReg     <= `OASC_RST_BYTE;  // see RULE14 see RULE16 see RULE17
         pinPortReg <= `OASC_RST_BYTE;
         pllReg     <= `OASC_RST_BYTE;
         usbDivReg  <= `OASC_RST_BYTE;
      end else begin
         haltFlag   <= next_haltFlag;   // see RULE24
         deepFlag   <= next_deepFlag;
         xtalFlag   <= next_xtalFlag;
         oscReg     <= next_oscReg;
         pinPortReg <= next_pinPortReg;
         pllReg     <= next_pllReg;
         usbDivReg  <= next_usbDivReg;
      end
   end

   // APB answer: ready in the first access cycle, data caught at setup
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= `OASC_RST_BIT;
         pslverr <= `OASC_RST_BIT;
         prdata  <= `OASC_ZERO_WORD;
      end else begin
         pready  <= setupPhase;
         if (setupPhase) begin
            pslverr <= ~mapped;
            prdata  <= pwrite ? `OASC_ZERO_WORD
                              : {`OASC_ZERO_PAD, readByte};
         end else if (accessDone) begin
            pslverr <= `OASC_RST_BIT;
            prdata  <= `OASC_ZERO_WORD;
         end
      end
   end

   // Registered control outputs, aligned with the state registers
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         coreHalted     <= `OASC_RST_BIT;
         deepStandby    <= `OASC_RST_BIT;
         crystalStandby <= `OASC_RST_BIT;
         mainOscRun     <= ~`OASC_RST_BIT;
         rcOscRun       <= ~`OASC_RST_BIT;
         subOscRun      <= `OASC_RST_BIT;
         pllRun         <= ~`OASC_RST_BIT;
         sysclkSource   <= `OASC_SRC_RC;
         sysclkHalve    <= ~`OASC_RST_BIT;
         pinBOut        <= `OASC_RST_BIT;
         pinBOe         <= `OASC_RST_BIT;
         pllRefMhz      <= `OASC_REF_MHZ0;
         usbDivSetting  <= `OASC_RST_BYTE;
      end else begin
         // Core waits while halted; peripherals are not gated here
         coreHalted     <= next_haltFlag;   // see RULE10
         deepStandby    <= next_deepFlag & ~next_xtalFlag;   // see RULE2
         crystalStandby <= next_deepFlag & next_xtalFlag;   // see RULE2
         // Any standby stops main and RC; on release each restarts unless its stop bit is set
         mainOscRun     <= ~next_oscReg[`OASC_OSC_MAIN_STOP]
                           & ~next_deepFlag;   // see RULE4 see RULE5 see RULE17
         rcOscRun       <= ~next_oscReg[`OASC_OSC_RC_STOP]
                           & ~next_deepFlag;   // see RULE4 see RULE5 see RULE16
         // Subclock survives crystal standby only
         subOscRun      <= next_oscReg[`OASC_OSC_PIN_MODE]
                           & ~(next_deepFlag & ~next_xtalFlag);   // see RULE3 see RULE5
         pllRun         <= ~next_pllReg[`OASC_PLL_VCO_STOP]
                           & ~next_pllReg[`OASC_PLL_CMP_STOP]
                           & ~next_deepFlag;   // see RULE22 see RULE3 see RULE5
         sysclkSource   <= next_source;   // see RULE14 see RULE4
         sysclkHalve    <= ~next_oscReg[`OASC_OSC_NO_HALF];   // see RULE13
         // Open drain: only ever pulls low
         pinBOut        <= `OASC_RST_BIT;
         pinBOe         <= ~next_oscReg[`OASC_OSC_PIN_MODE]
                           & next_pinPortReg[`OASC_PIN_DRIVE]
                           & ~next_pinPortReg[`OASC_PIN_VALUE];   // see RULE19 see RULE20
         pllRefMhz      <= next_refMhz;   // see RULE21
         usbDivSetting  <= next_usbDivReg;
      end
   end

endmodule
`default_nettype wire

// ===== tb/oasc_ctrl_checker.sv
// Port assertions for the oscillator and standby control block
`timescale 1ns/10ps
`default_nettype none
`include "oasc_ctrl_map.vh"
module oasc_ctrl_checker (
   input wire logic                    sys_clk,
   input wire logic                    resetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [`OASC_ADDR_W-1:0] paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [3:0]              pstrb,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic [4:0]              extIntWake,
   input wire logic                    port0Wake,
   input wire logic                    usbActiveWake,
   input wire logic                    remoteRxWake,
   input wire logic                    irqAccept,
   input wire logic                    coreHalted,
   input wire logic                    deepStandby,
   input wire logic                    crystalStandby,
   input wire logic                    mainOscRun,
   input wire logic                    rcOscRun,
   input wire logic                    subOscRun,
   input wire logic                    pllRun,
   input wire logic [1:0]              sysclkSource,
   input wire logic                    sysclkHalve
);
   wire logic anyWake = (|extIntWake) | port0Wake | usbActiveWake
                        | remoteRxWake;
   wire logic wrAcc   = psel & penable & pready & pwrite & pstrb[0];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_wake_held; anyWake [*3]; endsequence
   sequence s_power_read;
      psel && !penable && !pwrite && paddr == `OASC_ADDR_POWER;
   endsequence
   property p_power_upper; s_power_read |=> prdata[7:3] == 5'h1f; endproperty
   a_power_upper: assert property (p_power_upper) else $error("upper bits");
   property p_deep_stops;
      deepStandby |-> !mainOscRun && !rcOscRun && !subOscRun && !pllRun
                      && sysclkSource == `OASC_SRC_RC;
   endproperty
   a_deep_stops: assert property (p_deep_stops) else $error("deep stops");
   property p_deep_exit;
      $fell(deepStandby) && !$past(irqAccept) |-> mainOscRun && rcOscRun
         && coreHalted && sysclkSource == `OASC_SRC_RC;
   endproperty
   a_deep_exit: assert property (p_deep_exit) else $error("deep exit");
   property p_xtal_stops;
      crystalStandby |-> !mainOscRun && !rcOscRun && !pllRun && !deepStandby;
   endproperty
   a_xtal_stops: assert property (p_xtal_stops) else $error("xtal stops");
   property p_flags_by_sw;
      $rose(deepStandby) || $rose(crystalStandby)
         |-> $past(wrAcc && paddr == `OASC_ADDR_POWER);
   endproperty
   a_flags_by_sw: assert property (p_flags_by_sw) else $error("flag set");
   property p_wake_clears; s_wake_held |=> !deepStandby; endproperty
   a_wake_clears: assert property (p_wake_clears) else $error("wake");
   property p_deep_halt;
      $rose(deepStandby) && !$past(irqAccept) |-> coreHalted;
   endproperty
   a_deep_halt: assert property (p_deep_halt) else $error("deep halt");
   property p_irq_clear; irqAccept |=> !coreHalted; endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq clear");
   property p_halve;
      wrAcc && paddr == `OASC_ADDR_OSC |=> sysclkHalve == !$past(pwdata[7]);
   endproperty
   a_halve: assert property (p_halve) else $error("halving");
endmodule
`default_nettype wire

// ===== tb/oasc_ctrl_tb.sv
// Self-checking testbench for the oscillator and standby control block
`timescale 1ns/10ps
`default_nettype none
`include "oasc_ctrl_map.vh"
module oasc_ctrl_tb;
   localparam logic [17:0] aPwr = `OASC_ADDR_POWER;
   localparam logic [17:0] aOsc = `OASC_ADDR_OSC;
   localparam logic [17:0] aPll = `OASC_ADDR_PLL;
   localparam logic [17:0] aPin = `OASC_ADDR_PINPORT;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0]  pstrb = 4'hf;
   logic [7:0]  wake = 8'h00;
   logic        irqAccept = 1'b0, pinAIn = 1'b0, pinBIn = 1'b1;
   wire logic [31:0] prdata;
   wire logic        pready, pslverr, coreHalted, deepStandby, crystalStandby;
   wire logic        mainOscRun, rcOscRun, subOscRun, pllRun, sysclkHalve;
   wire logic        pinBOut, pinBOe;
   wire logic [1:0]  sysclkSource;
   wire logic [4:0]  pllRefMhz;
   wire logic [7:0]  usbDivSetting;
   wire logic [6:0]  runState = {mainOscRun, rcOscRun, subOscRun, pllRun,
                                 sysclkSource, sysclkHalve};
   int          errors = 0;
   int          checks_done = 0;
   logic [31:0] rd;
   logic        err;
   logic [4:0]  mhz [8] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h02,
                            5'h03, 5'h10};
   oasc_ctrl i_dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .extIntWake(wake[4:0]),
      .port0Wake(wake[5]), .usbActiveWake(wake[6]), .remoteRxWake(wake[7]),
      .irqAccept, .pinAIn, .pinBIn, .coreHalted, .deepStandby, .crystalStandby,
      .mainOscRun, .rcOscRun, .subOscRun, .pllRun, .sysclkSource,
      .sysclkHalve, .pinBOut, .pinBOe, .pllRefMhz, .usbDivSetting);
   always #10 sys_clk = ~sys_clk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      // Values read right after the edge are those sampled at it
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            chk("pready", 32'h1, 32'h0);
            print_verdict();
         end
         @(posedge sys_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
      @(negedge sys_clk);
   endtask
   task automatic rdchk(input logic [17:0] a, input logic [7:0] e, input string nm);
      apb(1'b0, a, 8'h00);
      chk(nm, {24'h000000, e}, rd);
   endtask
   task automatic irq_pulse;
      @(posedge sys_clk);
      irqAccept <= 1'b1;
      @(posedge sys_clk);
      irqAccept <= 1'b0;
      @(negedge sys_clk);
   endtask
   // Waits for both standby outputs to drop, bounded
   task automatic wait_release;
      int n;
      n = 0;
      while ((deepStandby | crystalStandby) !== 1'b0 && n < 10) begin
         @(negedge sys_clk);
         n++;
      end
      chk("standby release", 32'h0, {31'h0, deepStandby | crystalStandby});
      if ((deepStandby | crystalStandby) !== 1'b0) print_verdict();
   endtask
   task automatic t_reset;
      rdchk(aPwr, 8'hf8, "power");
      rdchk(aOsc, 8'h08, "osc");
      rdchk(aPll, 8'h00, "pll");
      rdchk(aPin, 8'h00, "pin port");
      rdchk(`OASC_ADDR_USB_CLOCK_DIVIDER_CTRL, 8'h00, "usb div");
      apb(1'b0, 18'h00000, 8'h00);
      chk("unmapped", 32'h1, {31'h0, err});
      chk("run", 32'h69, {25'h0, runState});
   endtask
   task automatic t_osc;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {i[2], 1'b0, i[1:0], 4'h0};
         wr(aOsc, d);
         chk("halve", {31'h0, !d[7]}, {31'h0, sysclkHalve});
         chk("src", (i[1:0] == 2) ? 2 : (i[1:0] == 0) ? 0 : 1, {30'h0, sysclkSource});
      end
      @(posedge sys_clk);
      pinAIn <= 1'b1;
      pinBIn <= 1'b0;
      wr(aOsc, 8'h3f);
      chk("stops", 32'h00, {30'h0, runState[6:5]});
      rdchk(aOsc, 8'h37, "osc pins");
      // Pin B changes before the write so its synchroniser settles
      @(posedge sys_clk);
      pinBIn <= 1'b1;
      wr(aOsc, 8'hc0);
      rdchk(aOsc, 8'hc8, "osc pin mode");
      @(posedge sys_clk);
      pstrb <= 4'he;
      wr(aOsc, 8'h00);
      @(posedge sys_clk);
      pstrb <= 4'hf;
      rdchk(aOsc, 8'hc8, "osc strobe");
      wr(aOsc, 8'h00);
      chk("starts", 32'h3, {30'h0, runState[6:5]});
   endtask
   task automatic t_pll;
      for (int i = 0; i < 8; i++) begin
         wr(aPll, {i[2:0], 5'h00});
         chk("mhz", {27'h0, mhz[i]}, {27'h0, pllRefMhz});
      end
      for (int j = 0; j < 4; j++) begin
         wr(aPll, {4'h0, j[1:0], 2'h0});
         chk("pll run", {31'h0, j == 0}, {31'h0, pllRun});
      end
      wr(`OASC_ADDR_USB_CLOCK_DIVIDER_CTRL, 8'h05);
      chk("usb div out", 32'h05, {24'h0, usbDivSetting});
   endtask
   task automatic t_pin;
      for (int j = 0; j < 4; j++) begin
         wr(aPin, {6'h3f, j[1:0]});
         chk("pin oe", {31'h0, j == 2}, {30'h0, pinBOut, pinBOe});
         rdchk(aPin, {6'h3f, j[1:0]}, "pin port");
      end
      wr(aOsc, 8'h40);
      wr(aPin, 8'h02);
      chk("pin oe mode", 32'h0, {31'h0, pinBOe});
   endtask
   task automatic t_halt;
      wr(aPwr, 8'h01);
      chk("halt", 32'h1, {31'h0, coreHalted});
      rdchk(aPwr, 8'hf9, "power halt");
      irq_pulse();
      chk("halt irq", 32'h0, {31'h0, coreHalted});
   endtask
   task automatic t_deep;
      for (int i = 0; i < 8; i++) begin
         wr(aOsc, 8'h53);
         wr(aPwr, 8'h02);
         chk("deep", 32'h5, {deepStandby, crystalStandby, coreHalted});
         chk("deep run", 32'h01, {25'h0, runState});
         rdchk(aOsc, 8'h48, "osc deep");
         @(posedge sys_clk);
         wake[i] <= 1'b1;
         wait_release();
         @(posedge sys_clk);
         wake <= 8'h00;
         @(negedge sys_clk);
         chk("deep exit", 32'h71, {25'h0, runState});
         rdchk(aPwr, 8'hf9, "power exit");
         irq_pulse();
      end
   endtask
   task automatic t_xtal;
      wr(aOsc, 8'he2);
      wr(aPwr, 8'h06);
      chk("xtal", 32'h3, {deepStandby, crystalStandby, coreHalted});
      chk("xtal run", 32'h14, {25'h0, runState});
      rdchk(aOsc, 8'hea, "osc xtal");
      @(posedge sys_clk);
      wake[7] <= 1'b1;
      wait_release();
      @(posedge sys_clk);
      wake <= 8'h00;
      rdchk(aPwr, 8'hfd, "power xtal");
      wr(aPwr, 8'h00);
      rdchk(aPwr, 8'hf8, "power clear");
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_osc();
      t_pll();
      t_pin();
      t_halt();
      t_deep();
      t_xtal();
      print_verdict();
   end
endmodule
bind oasc_ctrl oasc_ctrl_checker i_chk (.sys_clk, .resetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .extIntWake, .port0Wake,
   .usbActiveWake, .remoteRxWake, .irqAccept, .coreHalted, .deepStandby,
   .crystalStandby, .mainOscRun, .rcOscRun, .subOscRun, .pllRun, .sysclkSource,
   .sysclkHalve);
`default_nettype wire
